// ==== hdl/chip_id_pkg.sv ====
// Constants and types for the chip identity and boot strap block
package chip_id_pkg;

	// ------------------------------------------------------------
	// CPU word addresses
	// ------------------------------------------------------------
	localparam logic [15:0] BOOT_SELECT_ADDR  = 16'h1c34;
	localparam logic [15:0] CLOCK_CONFIG_ADDR = 16'h1c1f;

	// ------------------------------------------------------------
	// Register field layout
	// ------------------------------------------------------------
	localparam int BOOT_FIELD_LSB   = 5;
	localparam int BOOT_FIELD_MSB   = 10;
	localparam int BOOT_FIELD_WIDTH = 6;
	localparam int CLK_STATUS_BIT   = 0;
	localparam int FREQ_CODE_LSB    = 4;
	localparam logic [15:0] REG_RESET_VALUE = 16'h0000;

	// ------------------------------------------------------------
	// Identity word fields (values arbitrary)
	// ------------------------------------------------------------
	localparam logic [3:0]  ID_REVISION  = 4'h1;
	localparam logic [15:0] ID_PART_CODE = 16'h5a3c;
	localparam logic [10:0] ID_MAKER     = 11'h2a5;
	localparam logic        ID_FIXED_LSB = 1'h1;
	localparam int ID_REVISION_LSB = 28;
	localparam int ID_PART_LSB     = 12;
	localparam int ID_MAKER_LSB    = 1;

	// ------------------------------------------------------------
	// Strap capture timing
	// ------------------------------------------------------------
	localparam logic [3:0] CAPTURE_EDGE = 4'ha;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_COUNTING = 2'b01,
		ST_HELD     = 2'b10
	} capture_state_t;

	typedef enum logic [4:0] {
		FREQ_INTERNAL_12    = 5'b00001,
		FREQ_EXT_11P2896    = 5'b00010,
		FREQ_EXT_12_12P288  = 5'b00100,
		FREQ_EXT_16P8       = 5'b01000,
		FREQ_EXT_19P2       = 5'b10000
	} input_clock_t;

endpackage

// ==== hdl/strap_capture.sv ====
// Strap sampler that catches boot straps a fixed number of edges after reset
module strap_capture
	import chip_id_pkg::*;
(
	// Clock and reset
	input  wire logic                        clk_sys,
	input  wire logic                        reset,
	// Strap pins
	input  wire logic [BOOT_FIELD_WIDTH-1:0] strap_mem_addr,
	input  wire logic [BOOT_FIELD_WIDTH-1:0] strap_gpio,
	input  wire logic                        use_gpio_straps,
	input  wire logic                        clock_sel_pin,
	// Caught values
	output logic      [BOOT_FIELD_WIDTH-1:0] boot_select_strap,
	output logic                             clock_source_status,
	output logic                             capture_done
);

	capture_state_t              state;
	capture_state_t              next_state;
	logic [3:0]                  edge_count;
	logic [3:0]                  next_edge_count;
	logic [BOOT_FIELD_WIDTH-1:0] next_boot_select_strap;
	logic                        next_clock_source_status;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_state               = state;
		next_edge_count          = edge_count;
		next_boot_select_strap   = boot_select_strap;
		next_clock_source_status = clock_source_status;
		case (state)
			ST_COUNTING: begin
				next_edge_count = edge_count + 4'h1;
				if (edge_count == CAPTURE_EDGE - 4'h1) begin
					next_boot_select_strap   = use_gpio_straps ? strap_gpio : strap_mem_addr;
					next_clock_source_status = clock_sel_pin;
					next_state               = ST_HELD;
				end
			end
			ST_HELD: begin
				// Straps no longer looked at
				next_state = ST_HELD;
			end
			default: begin
				next_state = ST_COUNTING;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state               <= ST_COUNTING;
			edge_count          <= 4'h0;
			boot_select_strap   <= '0;
			clock_source_status <= 1'b0;
			capture_done        <= 1'b0;
		end else begin
			state               <= next_state;
			edge_count          <= next_edge_count;
			boot_select_strap   <= next_boot_select_strap;
			clock_source_status <= next_clock_source_status;
			capture_done        <= (next_state == ST_HELD);
		end
	end

endmodule

// ==== hdl/chip_identity_boot.sv ====
// Identity word scan path and boot-select strap registers
module chip_identity_boot
	import chip_id_pkg::*;
(
	// Clock and reset
	input  wire logic                                   clk_sys,
	input  wire logic                                   reset,

	// Boundary-scan identity path
	input  wire logic                                   scan_capture_id,
	input  wire logic                                   scan_shift_en,
	input  wire logic                                   scan_tdi,
	output logic                                        scan_tdo,
	output logic      [31:0]                            chip_identity_word,

	// Strap pins
	input  wire logic [20:15]                           memory_address_pins,
	input  wire logic [26:21]                           general_io_pins,
	input  wire logic                                   use_gpio_straps,
	input  wire logic                                   clock_sel_pin,

	// CPU register port
	input  wire logic                                   cpu_rd_strobe,
	input  wire logic                                   cpu_wr_strobe,
	input  wire logic [15:0]                            cpu_addr,
	input  wire logic [15:0]                            cpu_wdata,
	output logic      [15:0]                            cpu_rdata,
	output logic                                        cpu_rd_ack,
	output logic                                        cpu_wr_ack,

	// Boot status
	output logic      [chip_id_pkg::BOOT_FIELD_WIDTH-1:0] boot_select_strap,
	output logic                                        clock_source_status,
	output chip_id_pkg::input_clock_t                   input_clock_sel,
	output logic                                        straps_valid
);

	import chip_id_pkg::*;

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------

	// Fixed identity word, bit 0 forced high
	function automatic logic [31:0] identity_value();
		logic [31:0] word;
		word                                = 32'h0000_0000;
		word[ID_REVISION_LSB +: 4]          = ID_REVISION;
		word[ID_PART_LSB +: 16]             = ID_PART_CODE;
		word[ID_MAKER_LSB +: 11]            = ID_MAKER;
		word[0]                             = ID_FIXED_LSB;
		return word;
	endfunction

	// Input clock choice from upper boot bits and clock-source level
	function automatic input_clock_t decode_clock(
		input logic [1:0] code,
		input logic       clk_src
	);
		input_clock_t sel;
		sel = FREQ_INTERNAL_12;
		if (clk_src) begin
			case (code)
				2'h0:    sel = FREQ_EXT_11P2896;
				2'h1:    sel = FREQ_EXT_12_12P288;
				2'h2:    sel = FREQ_EXT_16P8;
				default: sel = FREQ_EXT_19P2;
			endcase
		end
		return sel;
	endfunction

	// Boot-select word: six caught bits at 10:5, the rest zero
	function automatic logic [15:0] boot_reg_value(
		input logic [BOOT_FIELD_WIDTH-1:0] boot_bits
	);
		logic [15:0] value;
		value                                = REG_RESET_VALUE;
		value[BOOT_FIELD_MSB:BOOT_FIELD_LSB] = boot_bits;
		return value;
	endfunction

	// Clock word: caught clock-source bit and one-hot input clock
	function automatic logic [15:0] clock_reg_value(
		input logic         clk_src,
		input input_clock_t clk_sel
	);
		logic [15:0] value;
		value                     = REG_RESET_VALUE;
		value[CLK_STATUS_BIT]     = clk_src;
		value[FREQ_CODE_LSB +: 5] = clk_sel;
		return value;
	endfunction

	// Read data for one CPU word address
	function automatic logic [15:0] read_value(
		input logic [15:0]                  addr,
		input logic [BOOT_FIELD_WIDTH-1:0]  boot_bits,
		input logic                         clk_src,
		input input_clock_t                 clk_sel
	);
		logic [15:0] value;
		value = REG_RESET_VALUE;
		if (addr == BOOT_SELECT_ADDR) begin
			value = boot_reg_value(boot_bits);
		end else if (addr == CLOCK_CONFIG_ADDR) begin
			value = clock_reg_value(clk_src, clk_sel);
		end
		return value;
	endfunction

	// ------------------------------------------------------------
	// Strap capture
	// ------------------------------------------------------------
	logic [BOOT_FIELD_WIDTH-1:0] caught_boot;
	logic                        caught_clk_src;
	logic                        caught_done;

	strap_capture u_strap_capture (
		.clk_sys             (clk_sys),
		.reset               (reset),
		.strap_mem_addr      (memory_address_pins),
		.strap_gpio          (general_io_pins),
		.use_gpio_straps     (use_gpio_straps),
		.clock_sel_pin       (clock_sel_pin),
		.boot_select_strap   (caught_boot),
		.clock_source_status (caught_clk_src),
		.capture_done        (caught_done)
	);

	// ------------------------------------------------------------
	// Boot status outputs
	// ------------------------------------------------------------
	logic [BOOT_FIELD_WIDTH-1:0] next_boot_select_strap;
	logic                        next_clock_source_status;
	input_clock_t                next_input_clock_sel;
	logic                        next_straps_valid;

	always_comb begin
		next_boot_select_strap   = caught_boot;
		next_clock_source_status = caught_clk_src;
		next_input_clock_sel     = decode_clock(caught_boot[5:4], caught_clk_src);
		next_straps_valid        = caught_done;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			boot_select_strap   <= '0;
			clock_source_status <= 1'b0;
			input_clock_sel     <= FREQ_INTERNAL_12;
			straps_valid        <= 1'b0;
		end else begin
			boot_select_strap   <= next_boot_select_strap;
			clock_source_status <= next_clock_source_status;
			input_clock_sel     <= next_input_clock_sel;
			straps_valid        <= next_straps_valid;
		end
	end

	// ------------------------------------------------------------
	// Identity scan path
	// ------------------------------------------------------------
	logic [31:0] id_shift;
	logic [31:0] next_id_shift;
	logic        next_scan_tdo;
	logic [31:0] next_chip_identity_word;

	always_comb begin
		next_id_shift           = id_shift;
		next_chip_identity_word = identity_value();
		if (scan_capture_id) begin
			next_id_shift = identity_value();
		end else if (scan_shift_en) begin
			next_id_shift = {scan_tdi, id_shift[31:1]};
		end
		next_scan_tdo = next_id_shift[0];
	end

	// Identity is constant, so it also holds through reset
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			id_shift <= identity_value();
			scan_tdo <= ID_FIXED_LSB;
		end else begin
			id_shift <= next_id_shift;
			scan_tdo <= next_scan_tdo;
		end
		chip_identity_word <= next_chip_identity_word;
	end

	// ------------------------------------------------------------
	// CPU register port
	// ------------------------------------------------------------
	logic [15:0] next_cpu_rdata;
	logic        next_cpu_rd_ack;
	logic        next_cpu_wr_ack;
	logic        unused_wdata;

	// Writes without a read in the same cycle are acknowledged and dropped: every register is read-only
	always_comb begin
		unused_wdata    = ^cpu_wdata;
		next_cpu_rd_ack = 1'b0;
		next_cpu_wr_ack = 1'b0;
		next_cpu_rdata  = 16'h0000;
		if (cpu_rd_strobe) begin
			// Read wins over a write in the same cycle
			next_cpu_rd_ack = 1'b1;
			next_cpu_rdata  = read_value(cpu_addr, boot_select_strap,
			                             clock_source_status, input_clock_sel);
		end else if (cpu_wr_strobe) begin
			next_cpu_wr_ack = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cpu_rdata  <= 16'h0000;
			cpu_rd_ack <= 1'b0;
			cpu_wr_ack <= 1'b0;
		end else begin
			cpu_rdata  <= next_cpu_rdata;
			cpu_rd_ack <= next_cpu_rd_ack;
			cpu_wr_ack <= next_cpu_wr_ack;
		end
	end

endmodule

// ==== sim/chip_identity_boot_checker.sv ====
// Concurrent checks for the identity and boot strap block
module chip_identity_boot_checker
	import chip_id_pkg::*;
(
	// Clock and reset
	input wire logic         clk_sys,
	input wire logic         reset,
	// Watched ports
	input wire logic [31:0]  chip_identity_word,
	input wire logic         scan_capture_id,
	input wire logic         scan_tdo,
	input wire logic [20:15] memory_address_pins,
	input wire logic [26:21] general_io_pins,
	input wire logic         use_gpio_straps,
	input wire logic         clock_sel_pin,
	input wire logic         cpu_rd_strobe,
	input wire logic         cpu_wr_strobe,
	input wire logic [15:0]  cpu_addr,
	input wire logic [15:0]  cpu_rdata,
	input wire logic         cpu_rd_ack,
	input wire logic         cpu_wr_ack,
	input wire logic [5:0]   boot_select_strap,
	input wire logic         clock_source_status,
	input chip_id_pkg::input_clock_t input_clock_sel,
	input wire logic         straps_valid
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [31:0] ID_WORD = {ID_REVISION, ID_PART_CODE, ID_MAKER, ID_FIXED_LSB};
	logic [7:0] edges;
	logic [7:0] next_edges;
	// Edges since reset release
	always_comb next_edges = (edges == 8'hff) ? edges : edges + 8'h01;
	always_ff @(posedge clk_sys) edges <= reset ? 8'h00 : next_edges;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	a_id_word_fixed: assert property (chip_identity_word == ID_WORD)
		else $error("identity word wrong");
	a_scan_lsb_one: assert property (scan_capture_id |=> scan_tdo)
		else $error("scan bit 0 low");
	a_capture_edge: assert property ($rose(straps_valid) |-> edges == 8'd11)
		else $error("capture on wrong edge");
	a_strap_source: assert property ($rose(straps_valid) |->
		clock_source_status == $past(clock_sel_pin, 2)
		&& boot_select_strap == ($past(use_gpio_straps, 2) ? $past(general_io_pins, 2)
		: $past(memory_address_pins, 2))) else $error("wrong strap levels caught");
	a_strap_hold: assert property (straps_valid |=> straps_valid && $stable(boot_select_strap)
		&& $stable(clock_source_status)) else $error("caught straps changed");
	a_freq_decode: assert property (straps_valid |-> input_clock_sel ==
		(clock_source_status ? 5'h02 << boot_select_strap[5:4] : 5'h01)) else $error("bad clock code");
	a_boot_read: assert property (cpu_rd_strobe && straps_valid
		&& cpu_addr == BOOT_SELECT_ADDR
		|=> cpu_rd_ack && cpu_rdata == {5'h00, boot_select_strap, 5'h00})
		else $error("bad boot read");
	a_clock_read: assert property (cpu_rd_strobe && straps_valid
		&& cpu_addr == CLOCK_CONFIG_ADDR
		|=> cpu_rdata == {7'h00, input_clock_sel, 3'h0, clock_source_status})
		else $error("bad clk read");
	a_rdata_idle: assert property (!cpu_rd_strobe |=> !cpu_rd_ack && cpu_rdata == 16'h0000)
		else $error("read data without read");
	a_write_dropped: assert property (cpu_wr_strobe && !cpu_rd_strobe |=> cpu_wr_ack)
		else $error("write not acknowledged");
	a_read_first: assert property (cpu_wr_strobe && cpu_rd_strobe
		|=> cpu_rd_ack && !cpu_wr_ack) else $error("read beside write mishandled");
	cover property ($rose(straps_valid));
	cover property (cpu_rd_strobe && cpu_wr_strobe);
	cover property (scan_capture_id);
endmodule
bind chip_identity_boot chip_identity_boot_checker chk (
	.clk_sys             (clk_sys),
	.reset               (reset),
	.chip_identity_word  (chip_identity_word),
	.scan_capture_id     (scan_capture_id),
	.scan_tdo            (scan_tdo),
	.memory_address_pins (memory_address_pins),
	.general_io_pins     (general_io_pins),
	.use_gpio_straps     (use_gpio_straps),
	.clock_sel_pin       (clock_sel_pin),
	.cpu_rd_strobe       (cpu_rd_strobe),
	.cpu_wr_strobe       (cpu_wr_strobe),
	.cpu_addr            (cpu_addr),
	.cpu_rdata           (cpu_rdata),
	.cpu_rd_ack          (cpu_rd_ack),
	.cpu_wr_ack          (cpu_wr_ack),
	.boot_select_strap   (boot_select_strap),
	.clock_source_status (clock_source_status),
	.input_clock_sel     (input_clock_sel),
	.straps_valid        (straps_valid)
);

// ==== sim/strap_board_model.sv ====
// Board model driving the boot straps around reset release
module strap_board_model
	import chip_id_pkg::*;
(
	// Clock, reset and wanted levels
	input  wire logic         clk_sys,
	input  wire logic         reset,
	input  wire logic [5:0]   strap_value,
	input  wire logic         src_gpio,
	input  wire logic         clk_src,
	// Strap pins
	output logic      [20:15] memory_address_pins,
	output logic      [26:21] general_io_pins,
	output logic              use_gpio_straps,
	output logic              clock_sel_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] held = 4'h0;
	logic       late;
	always_ff @(posedge clk_sys) held <= reset ? 4'h0 : held + {3'h0, held != 4'hf};
	// Wanted levels up to the tenth edge only, inverse after
	assign late = held >= 4'ha;
	assign memory_address_pins = (late || src_gpio) ? ~strap_value : strap_value;
	assign general_io_pins = (late || !src_gpio) ? ~strap_value : strap_value;
	assign use_gpio_straps = src_gpio ^ late;
	assign clock_sel_pin = clk_src ^ late;
endmodule

// ==== sim/chip_identity_boot_tb.sv ====
// Self-checking bench for the identity and boot strap block
module chip_identity_boot_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import chip_id_pkg::*;
	typedef struct packed {logic gpio; logic clk; logic [5:0] strap; logic [4:0] freq;} row_t;
	localparam logic [31:0] ID_WORD = {ID_REVISION, ID_PART_CODE, ID_MAKER, ID_FIXED_LSB};
	localparam row_t ROWS [5] = '{{1'b0, 1'b0, 6'h3f, 5'h01}, {1'b1, 1'b1, 6'h0a, 5'h02},
		{1'b0, 1'b1, 6'h15, 5'h04}, {1'b1, 1'b1, 6'h2c, 5'h08}, {1'b0, 1'b1, 6'h33, 5'h10}};
	logic         clk_sys = 1'b0, reset = 1'b1, scan_capture_id = 1'b0, scan_shift_en = 1'b0;
	logic         scan_tdi = 1'b0, cpu_rd_strobe = 1'b0, cpu_wr_strobe = 1'b0;
	logic [15:0]  cpu_addr = 16'h0000, cpu_wdata = 16'h0000, cpu_rdata, q;
	logic [5:0]   strap_value = 6'h00, boot_select_strap;
	logic         src_gpio = 1'b0, clk_src = 1'b0, ra, wa, use_gpio_straps, clock_sel_pin;
	logic         scan_tdo, cpu_rd_ack, cpu_wr_ack, clock_source_status, straps_valid;
	logic [31:0]  chip_identity_word, sh;
	logic [20:15] memory_address_pins;
	logic [26:21] general_io_pins;
	input_clock_t input_clock_sel;
	int           mismatches = 0, compares = 0, cycles = 0;
	chip_identity_boot dut (
		.clk_sys             (clk_sys),
		.reset               (reset),
		.scan_capture_id     (scan_capture_id),
		.scan_shift_en       (scan_shift_en),
		.scan_tdi            (scan_tdi),
		.scan_tdo            (scan_tdo),
		.chip_identity_word  (chip_identity_word),
		.memory_address_pins (memory_address_pins),
		.general_io_pins     (general_io_pins),
		.use_gpio_straps     (use_gpio_straps),
		.clock_sel_pin       (clock_sel_pin),
		.cpu_rd_strobe       (cpu_rd_strobe),
		.cpu_wr_strobe       (cpu_wr_strobe),
		.cpu_addr            (cpu_addr),
		.cpu_wdata           (cpu_wdata),
		.cpu_rdata           (cpu_rdata),
		.cpu_rd_ack          (cpu_rd_ack),
		.cpu_wr_ack          (cpu_wr_ack),
		.boot_select_strap   (boot_select_strap),
		.clock_source_status (clock_source_status),
		.input_clock_sel     (input_clock_sel),
		.straps_valid        (straps_valid)
	);
	strap_board_model board (
		.clk_sys             (clk_sys),
		.reset               (reset),
		.strap_value         (strap_value),
		.src_gpio            (src_gpio),
		.clk_src             (clk_src),
		.memory_address_pins (memory_address_pins),
		.general_io_pins     (general_io_pins),
		.use_gpio_straps     (use_gpio_straps),
		.clock_sel_pin       (clock_sel_pin)
	);
	always #2 clk_sys = ~clk_sys;
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic cpu_op(input logic rd, input logic wr, input logic [15:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		{cpu_rd_strobe, cpu_wr_strobe, cpu_addr, cpu_wdata} <= {rd, wr, a, d};
		@(posedge clk_sys);
		{cpu_rd_strobe, cpu_wr_strobe} <= 2'b00;
		#1 {q, ra, wa} = {cpu_rdata, cpu_rd_ack, cpu_wr_ack};
	endtask
	task automatic restart(input row_t r);
		@(posedge clk_sys);
		{reset, src_gpio, clk_src, strap_value} <= {1'b1, r.gpio, r.clk, r.strap};
		repeat (7) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (20) if (straps_valid !== 1'b1) @(posedge clk_sys);
		#1;
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			give_verdict();
		end
	end
	initial begin
		foreach (ROWS[i]) begin
			restart(ROWS[i]);
			chk("boot_select_strap", 32'(ROWS[i].strap), 32'(boot_select_strap));
			chk("clock_source_status", 32'(ROWS[i].clk), 32'(clock_source_status));
			chk("input_clock_sel", 32'(ROWS[i].freq), 32'(input_clock_sel));
			cpu_op(1'b1, 1'b0, BOOT_SELECT_ADDR, 16'h0000);
			chk("boot register", {21'h0, ROWS[i].strap, 5'h00}, 32'(q));
			cpu_op(1'b1, 1'b0, CLOCK_CONFIG_ADDR, 16'h0000);
			chk("clock register", {23'h0, ROWS[i].freq, 3'h0, ROWS[i].clk}, 32'(q));
			$display("test strap row %0d done", i);
		end
		cpu_op(1'b0, 1'b1, BOOT_SELECT_ADDR, 16'hffff);
		chk("write answer", 32'h0001_0000, {14'h0, ra, wa, q});
		cpu_op(1'b1, 1'b1, BOOT_SELECT_ADDR, 16'hffff);
		chk("read beside write", 32'h0002_0660, {14'h0, ra, wa, q});
		cpu_op(1'b1, 1'b0, 16'h1c35, 16'h0000);
		chk("unmapped read", 32'h0002_0000, {14'h0, ra, wa, q});
		$display("test register access done");
		@(posedge clk_sys);
		{scan_capture_id, scan_tdi} <= 2'b11;
		@(posedge clk_sys);
		{scan_capture_id, scan_shift_en} <= 2'b01;
		for (int i = 0; i < 32; i++) begin
			#1 sh[i] = scan_tdo;
			@(posedge clk_sys);
		end
		scan_shift_en <= 1'b0;
		#1 chk("scanned identity", ID_WORD, sh);
		chk("identity after shift", ID_WORD, chip_identity_word);
		@(posedge clk_sys);
		reset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 chk("reset state", 32'h41, {25'h0, scan_tdo, straps_valid, input_clock_sel});
		restart(ROWS[2]);
		chk("strap after reset", 32'h15, 32'(boot_select_strap));
		$display("test scan and reset done");
		give_verdict();
	end
endmodule
